// file: rtl/alias_exec_map.vh
`ifndef ALIAS_EXEC_MAP_VH
`define ALIAS_EXEC_MAP_VH
// Operation codes
`define OP_NONE 4'h0
`define OP_OR_IMM 4'h1
`define OP_AND_IMM 4'h2
`define OP_XOR_IMM 4'h3
`define OP_NOT 4'h4
`define OP_MSHIFT_LOG 4'h5
`define OP_MSHIFT_ARITH 4'h6
`define OP_SHL1 4'h7
`define OP_CLR 4'h8
`define OP_POP 4'h9
`define OP_POP_NODST 4'ha
// Register codes
`define REG_X0 4'h0
`define REG_Y0 4'h1
`define REG_Y1 4'h2
`define REG_A1 4'h3
`define REG_B1 4'h4
`define REG_R0 4'h5
`define REG_R3 4'h8
`define REG_N 4'h9
`define REG_A 4'ha
`define REG_B 4'hb
// Condition code bit positions
`define CC_C 0
`define CC_V 1
`define CC_Z 2
`define CC_N 3
`define ONES_MASK 16'hffff
`define SHIFT_CNT_BITS 4
`define SP_RESET 16'h0000
`endif

// file: rtl/field_unit.v
`default_nettype none
// ----------------------------------------
// Masked bit-field test and modify
// ----------------------------------------
module field_unit (
   input wire [1:0] kind_i,
   input wire [15:0] mask_i,
   input wire [15:0] data_i,
   output reg [15:0] result_o,
   output reg test_o
);
   // kind 0 set, 1 clear, 2 invert
   always @*
   begin
      case (kind_i)
         2'h0: test_o = ((data_i & mask_i) == 16'h0000);
         default: test_o = ((data_i & mask_i) == mask_i);
      endcase
      case (kind_i)
         2'h0: result_o = data_i | mask_i;
         2'h1: result_o = data_i & ~mask_i;
         default: result_o = data_i ^ mask_i;
      endcase
   end
endmodule // field_unit
`default_nettype wire

// file: rtl/alias_exec.v
// Function
// - OR-immediate runs masked field set with the mask unchanged
// - AND-immediate runs masked field clear with the complemented mask
// - XOR-immediate runs masked field invert with the mask
// - One's complement runs masked field invert with all-ones mask
// - Field ops are read-modify-write; carry takes the bit test result
// - Multi logical left shift behaves exactly as multi arithmetic left shift
// - First register is value, low four bits of second are count
// - Single arithmetic shift of 16-bit data register runs as logical shift
// - Single arithmetic shift of accumulator is true arithmetic shift
// - Clearing 16-bit register moves zero, condition codes kept
// - Accumulator clear uses its own accumulator clear operation
// - Pop with destination reads memory at stack pointer, then decrements
// - Pop without destination only decrements stack pointer
`include "alias_exec_map.vh"
`default_nettype none
module alias_exec (
   input wire mclk_i,
   input wire rst_i,
   input wire start_i,
   input wire [3:0] op_i,
   input wire [3:0] dst_i,
   input wire [15:0] imm_i,
   input wire [15:0] src1_i,
   input wire [15:0] src2_i,
   input wire [35:0] acc_i,
   input wire mem_dst_i,
   input wire [15:0] mem_addr_i,
   input wire [15:0] mem_rdata_i,
   input wire [15:0] reg_rdata_i,
   output reg [15:0] mem_addr_o,
   output reg mem_rd_o,
   output reg mem_wr_o,
   output reg [15:0] mem_wdata_o,
   output reg reg_wr_o,
   output reg [3:0] reg_sel_o,
   output reg [15:0] reg_wdata_o,
   output reg acc_wr_o,
   output reg [35:0] acc_wdata_o,
   output reg [3:0] ccr_o,
   output reg [15:0] sp_o,
   output reg busy_o,
   output reg done_o
);
   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam S_IDLE = 3'h1;
   localparam S_READ = 3'h2;
   localparam S_WRITE = 3'h4;

   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [3:0] op_ff;
   reg [3:0] dst_ff;
   reg [15:0] mask_ff;
   reg [1:0] kind_ff;
   reg memdst_ff;
   reg [1:0] nxt_kind;
   reg [15:0] nxt_mask;
   wire [15:0] fld_in;
   wire [15:0] fld_res;
   wire fld_test;
   wire [3:0] cnt;
   wire [15:0] msh;
   wire [15:0] msh_lost;
   wire [35:0] acc_sh;
   wire dd_dst;

   assign cnt = src2_i[`SHIFT_CNT_BITS-1:0];
   assign msh = src1_i << cnt;
   assign msh_lost = (cnt == 4'h0) ? 16'h0000 : (src1_i >> (5'h10 - {1'b0, cnt}));
   assign acc_sh = {acc_i[34:0], 1'b0};
   assign dd_dst = (dst_i != `REG_A) && (dst_i != `REG_B);
   assign fld_in = memdst_ff ? mem_rdata_i : reg_rdata_i;

   // Field test and modify datapath
   field_unit u_field (
      .kind_i(kind_ff),
      .mask_i(mask_ff),
      .data_i(fld_in),
      .result_o(fld_res),
      .test_o(fld_test)
   );

   // Mask and kind per alias
   always @*
   begin
      nxt_kind = 2'h2;
      nxt_mask = imm_i;
      case (op_i)
         `OP_OR_IMM: nxt_kind = 2'h0;
         `OP_AND_IMM:
         begin
            nxt_kind = 2'h1;
            nxt_mask = ~imm_i;
         end
         `OP_XOR_IMM: nxt_kind = 2'h2;
         `OP_NOT: nxt_mask = `ONES_MASK;
         default: nxt_kind = 2'h2;
      endcase
   end

   // Next state
   always @*
   begin
      nxt_state = S_IDLE;
      case (state_ff)
         S_IDLE:
            if (start_i && (op_ff != `OP_POP) && (op_i >= `OP_OR_IMM) && (op_i <= `OP_NOT))
               nxt_state = S_READ;
         S_READ: nxt_state = S_WRITE;
         S_WRITE: nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   // ----------------------------------------
   // Sequencer and datapath registers
   // ----------------------------------------
   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_ff <= S_IDLE;
         op_ff <= `OP_NONE;
         dst_ff <= 4'h0;
         mask_ff <= 16'h0000;
         kind_ff <= 2'h0;
         memdst_ff <= 1'b0;
         mem_addr_o <= 16'h0000;
         mem_rd_o <= 1'b0;
         mem_wr_o <= 1'b0;
         mem_wdata_o <= 16'h0000;
         reg_wr_o <= 1'b0;
         reg_sel_o <= 4'h0;
         reg_wdata_o <= 16'h0000;
         acc_wr_o <= 1'b0;
         acc_wdata_o <= 36'h000000000;
         ccr_o <= 4'h0;
         sp_o <= `SP_RESET;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         mem_rd_o <= 1'b0;
         mem_wr_o <= 1'b0;
         reg_wr_o <= 1'b0;
         acc_wr_o <= 1'b0;
         done_o <= 1'b0;
         busy_o <= (nxt_state != S_IDLE);
         case (state_ff)
            S_IDLE:
               if (op_ff == `OP_POP)
               begin
                  // Pop data lands one cycle after the read, start ignored
                  op_ff <= `OP_NONE;
                  reg_wr_o <= 1'b1;
                  reg_wdata_o <= mem_rdata_i;
                  done_o <= 1'b1;
               end
               else if (start_i)
               begin
                  op_ff <= op_i;
                  dst_ff <= dst_i;
                  mask_ff <= nxt_mask;
                  kind_ff <= nxt_kind;
                  memdst_ff <= mem_dst_i;
                  reg_sel_o <= dst_i;
                  case (op_i)
                     `OP_OR_IMM, `OP_AND_IMM, `OP_XOR_IMM, `OP_NOT:
                     begin
                        // Read phase of read-modify-write
                        mem_addr_o <= mem_addr_i;
                        mem_rd_o <= mem_dst_i;
                     end
                     `OP_MSHIFT_LOG, `OP_MSHIFT_ARITH:
                     begin
                        // Shared shift datapath
                        reg_wr_o <= 1'b1;
                        reg_wdata_o <= msh;
                        ccr_o[`CC_C] <= msh_lost != 16'h0000;
                        ccr_o[`CC_V] <= 1'b0;
                        ccr_o[`CC_Z] <= msh == 16'h0000;
                        ccr_o[`CC_N] <= msh[15];
                        done_o <= 1'b1;
                     end
                     `OP_SHL1:
                        if (dd_dst)
                        begin
                           // Logical shift with logical flags
                           reg_wr_o <= 1'b1;
                           reg_wdata_o <= {src1_i[14:0], 1'b0};
                           ccr_o[`CC_C] <= src1_i[15];
                           ccr_o[`CC_V] <= 1'b0;
                           ccr_o[`CC_Z] <= src1_i[14:0] == 15'h0000;
                           ccr_o[`CC_N] <= src1_i[14];
                           done_o <= 1'b1;
                        end
                        else
                        begin
                           // True arithmetic shift of accumulator
                           acc_wr_o <= 1'b1;
                           acc_wdata_o <= acc_sh;
                           ccr_o[`CC_C] <= acc_i[35];
                           ccr_o[`CC_V] <= acc_i[35] ^ acc_i[34];
                           ccr_o[`CC_Z] <= acc_sh == 36'h000000000;
                           ccr_o[`CC_N] <= acc_sh[35];
                           done_o <= 1'b1;
                        end
                     `OP_CLR:
                        if (dd_dst)
                        begin
                           // Zero move, flags untouched
                           reg_wr_o <= 1'b1;
                           reg_wdata_o <= 16'h0000;
                           done_o <= 1'b1;
                        end
                        else
                        begin
                           // Accumulator clear path
                           acc_wr_o <= 1'b1;
                           acc_wdata_o <= 36'h000000000;
                           ccr_o[`CC_Z] <= 1'b1;
                           ccr_o[`CC_N] <= 1'b0;
                           ccr_o[`CC_V] <= 1'b0;
                           done_o <= 1'b1;
                        end
                     `OP_POP:
                     begin
                        // Read at stack pointer, then decrement
                        mem_addr_o <= sp_o;
                        mem_rd_o <= 1'b1;
                        sp_o <= sp_o - 16'h0001;
                     end
                     `OP_POP_NODST:
                     begin
                        sp_o <= sp_o - 16'h0001;
                        done_o <= 1'b1;
                     end
                     default: done_o <= 1'b0;
                  endcase
               end
            S_READ:
            begin
               // Modify and write back, carry gets the test
               ccr_o[`CC_C] <= fld_test;
               mem_wr_o <= memdst_ff;
               mem_wdata_o <= fld_res;
               reg_wr_o <= ~memdst_ff;
               reg_wdata_o <= fld_res;
            end
            S_WRITE:
            begin
               op_ff <= `OP_NONE;
               done_o <= 1'b1;
            end
            default: op_ff <= `OP_NONE;
         endcase
      end
   end
endmodule // alias_exec
`default_nettype wire

// file: tb/alias_exec_sva.sv
`include "alias_exec_map.vh"
`default_nettype none
module alias_exec_sva (
   input wire logic mclk_i, rst_i, start_i, mem_dst_i, mem_rd_o, mem_wr_o,
   input wire logic reg_wr_o, acc_wr_o, busy_o, done_o,
   input wire logic [3:0] op_i, dst_i, ccr_o,
   input wire logic [15:0] imm_i, src1_i, src2_i, reg_rdata_i, mem_addr_o, reg_wdata_o, sp_o,
   input wire logic [35:0] acc_wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pend_ff;
   wire logic take = start_i && !busy_o && !pend_ff;
   // Pop take blocks the next cycle
   always_ff @(posedge mclk_i or posedge rst_i)
      if (rst_i)
         pend_ff <= 1'b0;
      else
         pend_ff <= take && op_i == `OP_POP;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_done; done_o |=> !done_o; endproperty
   a_done: assert property (p_done) else $error("done held too long");
   property p_pop; take && op_i == `OP_POP |=> mem_rd_o && mem_addr_o == $past(sp_o)
      && sp_o == $past(sp_o) - 16'h1 ##1 reg_wr_o && done_o; endproperty
   a_pop: assert property (p_pop) else $error("pop sequence wrong");
   property p_popnd; take && op_i == `OP_POP_NODST |=> sp_o == $past(sp_o) - 16'h1
      && !mem_rd_o && !reg_wr_o && !acc_wr_o && done_o; endproperty
   a_popnd: assert property (p_popnd) else $error("bare pop wrong");
   property p_clr16; take && op_i == `OP_CLR && dst_i != `REG_A && dst_i != `REG_B
      |=> reg_wr_o && reg_wdata_o == 16'h0 && $stable(ccr_o) && done_o; endproperty
   a_clr16: assert property (p_clr16) else $error("register clear wrong");
   property p_clracc; take && op_i == `OP_CLR && (dst_i == `REG_A || dst_i == `REG_B)
      |=> acc_wr_o && acc_wdata_o == 36'h0 && !reg_wr_o && ccr_o[`CC_Z]; endproperty
   a_clracc: assert property (p_clracc) else $error("acc clear wrong");
   property p_msh; take && (op_i == `OP_MSHIFT_LOG || op_i == `OP_MSHIFT_ARITH) |=> reg_wr_o
      && reg_wdata_o == ($past(src1_i) << $past(src2_i[3:0])); endproperty
   a_msh: assert property (p_msh) else $error("multi shift wrong");
   property p_fmem; take && op_i >= `OP_OR_IMM && op_i <= `OP_NOT && mem_dst_i
      |=> mem_rd_o ##1 mem_wr_o ##1 done_o; endproperty
   a_fmem: assert property (p_fmem) else $error("field rmw order wrong");
   property p_busy; take && op_i >= `OP_OR_IMM && op_i <= `OP_NOT
      |=> busy_o ##1 busy_o ##1 !busy_o && done_o; endproperty
   a_busy: assert property (p_busy) else $error("busy window wrong");
   property p_or; take && op_i == `OP_OR_IMM && !mem_dst_i |=> ##1 reg_wr_o
      && reg_wdata_o == ($past(reg_rdata_i) | $past(imm_i, 2))
      && ccr_o[`CC_C] == (($past(reg_rdata_i) & $past(imm_i, 2)) == 16'h0); endproperty
   a_or: assert property (p_or) else $error("or immediate wrong");
endmodule // alias_exec_sva
bind alias_exec alias_exec_sva u_sva (.*);
`default_nettype wire

// file: tb/xmem_model.sv
`default_nettype none
module xmem_model (
   input wire logic mclk_i, mem_rd_o, mem_wr_o,
   input wire logic [3:0] dst_i,
   input wire logic [15:0] mem_addr_o, mem_wdata_o,
   output logic [15:0] mem_rdata_i, reg_rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [16];
   logic [15:0] rf [16];
   logic [15:0] q_ff = 16'h5a5a;
   // Read data held one cycle, then scrambled
   always @(posedge mclk_i)
   begin
      q_ff <= mem_rd_o ? mem[mem_addr_o[3:0]] : ~q_ff;
      if (mem_wr_o)
         mem[mem_addr_o[3:0]] <= mem_wdata_o;
   end
   assign mem_rdata_i = mem_rd_o ? mem[mem_addr_o[3:0]] : q_ff;
   assign reg_rdata_i = rf[dst_i];
endmodule // xmem_model
`default_nettype wire

// file: tb/test_alias_exec.sv
`include "alias_exec_map.vh"
`default_nettype none
module test_alias_exec;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 0, rst_i = 1, start_i = 0, mem_dst_i = 0;
   logic mem_rd_o, mem_wr_o, reg_wr_o, acc_wr_o, busy_o, done_o;
   logic [3:0] op_i = 0, dst_i = 0, reg_sel_o, ccr_o;
   logic [15:0] imm_i = 0, src1_i = 0, src2_i = 0, mem_addr_i = 0, mem_rdata_i, reg_rdata_i;
   logic [15:0] mem_addr_o, mem_wdata_o, reg_wdata_o, sp_o, rw;
   logic [35:0] acc_i = 0, acc_wdata_o, aw;
   int fails = 0, cmp_count = 0, cyc = 0;
   alias_exec dut (.*);
   xmem_model pm (.*);
   always #12.5 mclk_i = ~mclk_i;
   // Hang guard
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         give_verdict();
      end
   end
   task automatic check(input string nm, input logic [35:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One operation, waits for done, latches written data
   task automatic run(input logic [3:0] op, dst, input logic [15:0] imm, s1, s2,
      input logic md);
      int n;
      n = 0;
      rw = 16'hdead;
      aw = 36'hdead;
      @(posedge mclk_i);
      #2 {op_i, dst_i, imm_i, src1_i, src2_i, mem_dst_i, start_i} = {op, dst, imm, s1, s2, md, 1'b1};
      @(posedge mclk_i);
      #2 start_i = 1'b0;
      do
      begin
         if (reg_wr_o === 1'b1) rw = reg_wdata_o;
         if (acc_wr_o === 1'b1) aw = acc_wdata_o;
         if (done_o === 1'b1) break;
         @(posedge mclk_i);
         #2 n++;
      end while (n < 8);
      check("done", done_o, 1'b1);
   endtask
   task automatic t_field();
      logic [15:0] d, m, e, k;
      d = 16'ha5c3;
      m = 16'h0ff0;
      pm.rf[`REG_Y0] = d;
      for (int i = 1; i <= 4; i++)
      begin
         e = (i == 1) ? d | m : (i == 2) ? d & m : (i == 3) ? d ^ m : ~d;
         k = (i == 2) ? ~m : (i == 4) ? `ONES_MASK : m;
         run(i[3:0], `REG_Y0, m, 0, 0, 0);
         check("field", rw, e);
         check("carry", ccr_o[`CC_C], (i == 1) ? (d & k) == 0 : (d & k) == k);
      end
      run(`OP_OR_IMM, `REG_Y0, 16'h5a3c, 0, 0, 0);
      check("set all", rw, 16'hffff);
      check("set carry", ccr_o[`CC_C], 1'b1);
      run(`OP_AND_IMM, `REG_Y0, 16'h5a3c, 0, 0, 0);
      check("clr all", rw, 16'h0000);
      check("clr carry", ccr_o[`CC_C], 1'b1);
      run(`OP_XOR_IMM, `REG_Y0, d, 0, 0, 0);
      check("inv all", rw, 16'h0000);
      check("inv carry", ccr_o[`CC_C], 1'b1);
      pm.mem[6] = 16'h1200;
      mem_addr_i = 16'h0006;
      run(`OP_XOR_IMM, `REG_X0, 16'h0204, 0, 0, 1);
      check("memory", pm.mem[6], 16'h1004);
   endtask
   task automatic t_shift();
      run(`OP_MSHIFT_LOG, `REG_Y1, 0, 16'h8421, 16'hfff3, 0);
      check("lshift", rw, 16'h2108);
      check("lcarry", ccr_o[`CC_C], 1'b1);
      run(`OP_MSHIFT_ARITH, `REG_Y1, 0, 16'h8421, 16'hfff3, 0);
      check("ashift", rw, 16'h2108);
      check("acarry", ccr_o[`CC_C], 1'b1);
      run(`OP_SHL1, `REG_X0, 0, 16'h4000, 0, 0);
      check("shl1", rw, 16'h8000);
      check("shl1 v", ccr_o[`CC_V], 1'b0);
      acc_i = 36'h400000001;
      run(`OP_SHL1, `REG_A, 0, 0, 0, 0);
      check("acc shl1", aw, 36'h800000002);
      check("acc v", ccr_o[`CC_V], 1'b1);
   endtask
   task automatic t_clr();
      logic [3:0] cc;
      cc = ccr_o;
      run(`OP_CLR, `REG_R0, 0, 0, 0, 0);
      check("clr", rw, 16'h0);
      check("clr ccr", ccr_o, cc);
      run(`OP_CLR, `REG_B, 0, 0, 0, 0);
      check("clr acc", aw, 36'h0);
      check("clr z", ccr_o[`CC_Z], 1'b1);
   endtask
   task automatic t_pop();
      pm.mem[0] = 16'h1234;
      run(`OP_POP, `REG_Y1, 0, 0, 0, 0);
      check("pop data", rw, 16'h1234);
      check("pop dst", reg_sel_o, `REG_Y1);
      check("pop sp", sp_o, 16'hffff);
      run(`OP_POP_NODST, `REG_Y1, 0, 0, 0, 0);
      check("bare sp", sp_o, 16'hfffe);
      check("bare data", rw, 16'hdead);
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge mclk_i);
      #2 rst_i = 1'b0;
      check("sp reset", sp_o, `SP_RESET);
      t_pop();
      t_field();
      t_shift();
      t_clr();
      give_verdict();
   end
endmodule // test_alias_exec
`default_nettype wire
